// ---- tb/usr_slave_mdl.sv ----
// Purpose: Serial slave that shifts words out on the master's clock
// Assumes: Word k is {k[0], a6h + k*3bh}, sent LSB first
// Notes:   Line is inverted once a word's last bit is taken
`timescale 1ns/100ps
module usr_slave_mdl (
	input  wire logic rst,  // Restart the word sequence
	input  wire logic nine, // Nine bits per word
	input  wire logic ck,   // Shift clock seen on the pin
	output logic      dt    // Data line to the master
);
	logic [3:0] idx; // Bit within word
	logic [7:0] k;   // Word number
	logic [8:0] w;   // Word being sent
	assign w = {k[0], 8'ha6 + k * 8'h3b};
	initial dt = 1'b0;
	// Bit goes out on the rise, long before the sampling fall
	always @(posedge ck or posedge rst) begin
		if (rst) begin
			idx <= 4'h0;
			k <= 8'h00;
		end else begin
			dt <= w[idx];
			if (idx == (nine ? 4'h8 : 4'h7)) begin
				idx <= 4'h0;
				k <= k + 8'h01;
			end else begin
				idx <= idx + 4'h1;
			end
		end
	end
	// Released line shows a changed level
	always @(negedge ck) begin
		if (idx == 4'h0) dt <= ~dt;
	end
endmodule

// ---- tb/usr_sync_rx_tb.sv ----
// Purpose: Register-level bench for the synchronous receive block
// Assumes: Divisor 3 gives a 320 ns shift clock
// Notes:   Words are checked against the slave model's sequence
`timescale 1ns/100ps
module usr_sync_rx_tb;
	import usr_pkg::*;
	logic CLK = 0, SYS_RST = 1, WR = 0, RD = 0, mrst = 1, nine = 0; // Drives
	logic DT_I, CK_O, CK_OE, IRQ; // Pins
	logic [7:0] ADDR = 0, WDATA = 0, RDATA; // Register port
	int err_count = 0, checks = 0, cyc = 0; // Tallies
	usr_sync_rx usr_sync_rx_inst (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .DT_I(DT_I), .CK_O(CK_O), .CK_OE(CK_OE), .IRQ(IRQ));
	usr_slave_mdl usr_slave_mdl_inst (.rst(mrst), .nine(nine), .ck(CK_O & CK_OE), .dt(DT_I));
	// Clock and hang ceiling
	always #20 CLK = ~CLK;
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			conclude();
		end
	end
	task automatic chk(string n, logic [7:0] got, logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
		#1;
	endtask
	task automatic rdv(logic [7:0] a, output logic [7:0] v);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 v = RDATA;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		logic [7:0] v;
		rdv(a, v);
		chk($sformatf("reg %h", a), v, e);
	endtask
	task automatic poll(logic [7:0] a, logic [7:0] m);
		logic [7:0] v = 0;
		for (int n = 0; n < 400 && (v & m) !== m; n++) rdv(a, v);
		chk("poll", v & m, m);
	endtask
	task automatic conclude();
		if (err_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge CLK);
		SYS_RST <= 0;
		mrst <= 0;
		#1 chk("ck_oe", CK_OE, 8'h00);
		rd(OFS_PERIPH_IRQ_ENABLES, RST_PERIPH_EN);
		rd(8'h55, 8'h00);
		wr(OFS_BAUD_DIVISOR, 8'h03);
		wr(OFS_PORT_MODE, 8'h90);
		wr(OFS_RX_STATUS_CONTROL, 8'h80);
		chk("ck_oe", CK_OE, 8'h01);
		wr(OFS_RX_STATUS_CONTROL, 8'ha0);
		poll(OFS_PERIPH_IRQ_FLAGS, 8'h20);
		wr(OFS_PERIPH_IRQ_ENABLES, 8'h20);
		chk("irq", IRQ, 8'h00);
		wr(OFS_IRQ_CONTROL, 8'hc0);
		chk("irq", IRQ, 8'h01);
		repeat (100) @(posedge CLK);
		chk("ck_o", CK_O, 8'h00);
		rd(OFS_RX_STATUS_CONTROL, 8'h80);
		rd(OFS_RX_DATA_BUFFER, 8'ha6);
		wr(OFS_PERIPH_IRQ_FLAGS, 8'hff);
		rd(OFS_PERIPH_IRQ_FLAGS, 8'h00);
		chk("irq", IRQ, 8'h00);
		nine <= 1;
		mrst <= 1;
		@(posedge CLK);
		mrst <= 0;
		wr(OFS_RX_STATUS_CONTROL, 8'hd0);
		poll(OFS_RX_STATUS_CONTROL, 8'h02);
		rd(OFS_RX_STATUS_CONTROL, 8'hd2);
		rd(OFS_RX_DATA_BUFFER, 8'ha6);
		rd(OFS_RX_STATUS_CONTROL, 8'hd3);
		rd(OFS_RX_DATA_BUFFER, 8'he1);
		repeat (80) @(posedge CLK);
		rd(OFS_PERIPH_IRQ_FLAGS, 8'h00);
		wr(OFS_RX_STATUS_CONTROL, 8'hc0);
		rd(OFS_RX_STATUS_CONTROL, 8'hc0);
		chk("ck_o", CK_O, 8'h00);
		// Both enables set: reception must run on as continuous
		mrst <= 1;
		@(posedge CLK);
		mrst <= 0;
		wr(OFS_RX_STATUS_CONTROL, 8'hf0);
		poll(OFS_RX_STATUS_CONTROL, 8'h02);
		rd(OFS_RX_STATUS_CONTROL, 8'hf2);
		rd(OFS_RX_DATA_BUFFER, 8'ha6);
		wr(OFS_RX_STATUS_CONTROL, 8'hc0);
		rd(OFS_RX_STATUS_CONTROL, 8'hc1);
		conclude();
	end
endmodule

// ---- verilog/usr_pkg.sv ----
// Purpose: Shared constants and types for the synchronous master receive block
// Assumes: Byte-wide register port with an 8-bit address
// Notes:   Each offset, field position and count is named once here, with the irq_control, enables and divisor reset values

package usr_pkg;

	// ------------------------------------------------------------
	// Register port widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;                       // Register address width
	localparam int DATA_W = 8;                       // Register data width

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_IRQ_CONTROL         = 8'h0b; // Global and peripheral enables
	localparam logic [7:0] OFS_PERIPH_IRQ_FLAGS    = 8'h0c; // Peripheral flags
	localparam logic [7:0] OFS_PERIPH_IRQ_ENABLES  = 8'h8c; // Peripheral enables
	localparam logic [7:0] OFS_RX_STATUS_CONTROL   = 8'h18; // Receive status and control
	localparam logic [7:0] OFS_RX_DATA_BUFFER      = 8'h1a; // Receive data buffer
	localparam logic [7:0] OFS_PORT_MODE           = 8'h98; // Clocked mode and clock source
	localparam logic [7:0] OFS_BAUD_DIVISOR        = 8'h99; // Shift clock divisor

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_GLOBAL_IRQ_EN   = 7;          // irq_control
	localparam int BIT_PERIPH_IRQ_EN   = 6;          // irq_control
	localparam int BIT_RX_FLAG         = 5;          // peripheral_irq_flags
	localparam int BIT_RX_IRQ_EN       = 5;          // peripheral_irq_enables
	localparam int BIT_SERIAL_PORT_EN  = 7;          // receive_status_control
	localparam int BIT_NINE_BIT_SEL    = 6;          // receive_status_control
	localparam int BIT_SINGLE_RX_EN    = 5;          // receive_status_control
	localparam int BIT_CONT_RX_EN      = 4;          // receive_status_control
	localparam int BIT_OVERRUN         = 1;          // receive_status_control
	localparam int BIT_NINTH_RX        = 0;          // receive_status_control
	localparam int BIT_MASTER_CLK_SRC  = 7;          // port mode
	localparam int BIT_CLOCKED_MODE    = 4;          // port mode

	// ------------------------------------------------------------
	// Reset values and counts
	// ------------------------------------------------------------
	localparam logic [7:0] RST_IRQ_CONTROL  = 8'h00; // irq_control after reset
	localparam logic [7:0] RST_PERIPH_EN    = 8'h00; // peripheral_irq_enables after reset
	localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00; // Divisor after reset
	localparam logic [3:0] BITS_SHORT       = 4'h8;  // Bits per eight-bit word
	localparam logic [3:0] BITS_LONG        = 4'h9;  // Bits per nine-bit word
	localparam logic [1:0] FIFO_DEPTH       = 2'h2;  // Receive buffer entries

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic       ninth;                           // Ninth received bit
		logic [7:0] data;                            // Low eight bits
	} usr_word_t;

	typedef enum logic {
		ST_IDLE,                                     // Clock idle low
		ST_SHIFT                                     // Clocking bits in
	} usr_state_t;

endpackage

// ---- verilog/usr_rx_fifo.sv ----
// Purpose: Two-entry receive buffer holding data word and ninth bit together
// Assumes: Caller pushes only when not full and pops only on a buffer read
// Notes:   Head is visible combinationally so the ninth bit tracks the next word

`timescale 1ns/100ps

module usr_rx_fifo
	import usr_pkg::*;
(
	input  logic             clk,       // System clock
	input  logic             rst,       // Asynchronous reset, active high
	input  logic             push,      // Store a finished word
	input  usr_pkg::usr_word_t push_word, // Word to store
	input  logic             pop,       // Drop the head word
	output usr_pkg::usr_word_t head,    // Oldest word
	output logic             full,      // Both entries hold words
	output logic             empty,     // No word held
	output logic [1:0]       count      // Words held
);

	// ------------------------------------------------------------
	// Storage and pointers
	// ------------------------------------------------------------
	usr_word_t  mem_ff [0:1];                        // Buffer entries
	logic       wr_ptr_ff;                           // Next entry to fill
	logic       rd_ptr_ff;                           // Oldest entry
	logic [1:0] count_ff;                            // Fill level
	logic       do_push;                             // Push accepted
	logic       do_pop;                              // Pop accepted

	assign full    = (count_ff == FIFO_DEPTH);
	assign empty   = (count_ff == 2'h0);
	assign count   = count_ff;
	assign head    = mem_ff[rd_ptr_ff];
	assign do_push = push && !full;
	assign do_pop  = pop && !empty;

	// Entry write; entries need no reset
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem_ff[wr_ptr_ff] <= push_word;
		end
	end

	// Pointers and fill level, oldest word leaves first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			count_ff  <= 2'h0;
		end else begin
			wr_ptr_ff <= wr_ptr_ff ^ do_push;
			rd_ptr_ff <= rd_ptr_ff ^ do_pop;
			count_ff  <= count_ff + {1'b0, do_push} - {1'b0, do_pop};
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_fifo_level_bound: assert property (@(posedge clk) disable iff (rst)
		count_ff <= FIFO_DEPTH)
		else $error("Receive buffer level above two");

endmodule

// ---- verilog/usr_sync_rx.sv ----
// Purpose: Receive path of a serial port in synchronous master mode
// Assumes: Register port with one-cycle strobes, read data one cycle later
// Notes:   Shift clock is made here from the system clock; data pin is synchronised
//
// Contract
// - Clocked mode plus either enable starts reception
// - Sample data on falling shift clock edge
// - Single enable takes one word, stops
// - Continuous enable receives until software clears
// - Both enables set behaves as continuous
// - Finished word moves into buffer if room
// - Receive flag set once word is buffered
// - Receive irq enable gates the flag
// - Flag read-only, clears when buffer empty
// - Buffer is two-word FIFO, read in order
// - Full buffer at word end sets overrun
// - Overrun blocks all transfers into buffer
// - Clearing continuous enable clears overrun
// - Ninth bit buffered, read updates it
// - Nine-bit select picks nine-bit words
// - Global and peripheral enables gate interrupt

`timescale 1ns/100ps

module usr_sync_rx
	import usr_pkg::*;
(
	input  logic                      CLK,     // System clock, 25 MHz
	input  logic                      SYS_RST, // Asynchronous reset, active high
	input  logic [usr_pkg::ADDR_W-1:0] ADDR,   // Register address
	input  logic [usr_pkg::DATA_W-1:0] WDATA,  // Register write data
	input  logic                      WR,      // Write strobe
	input  logic                      RD,      // Read strobe
	output logic [usr_pkg::DATA_W-1:0] RDATA,  // Read data, cycle after strobe
	input  logic                      DT_I,    // Serial data pin level
	output logic                      CK_O,    // Shift clock pin level
	output logic                      CK_OE,   // Shift clock pin drive enable
	output logic                      IRQ      // Receive interrupt request
);

	import usr_pkg::*;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------

	// Match one register offset
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	logic wr_irq_ctl;                                // Write irq_control
	logic wr_periph_en;                              // Write peripheral enables
	logic wr_rx_ctl;                                 // Write receive status/control
	logic wr_port_mode;                              // Write port mode
	logic wr_baud;                                   // Write baud divisor
	logic rd_rx_buf;                                 // Read receive data buffer

	assign wr_irq_ctl   = WR && hit(ADDR, OFS_IRQ_CONTROL);
	assign wr_periph_en = WR && hit(ADDR, OFS_PERIPH_IRQ_ENABLES);
	assign wr_rx_ctl    = WR && hit(ADDR, OFS_RX_STATUS_CONTROL);
	assign wr_port_mode = WR && hit(ADDR, OFS_PORT_MODE);
	assign wr_baud      = WR && hit(ADDR, OFS_BAUD_DIVISOR);
	assign rd_rx_buf    = RD && hit(ADDR, OFS_RX_DATA_BUFFER);

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [7:0] irq_ctl_ff;                          // irq_control contents
	logic [7:0] periph_en_ff;                        // peripheral_irq_enables contents
	logic       port_en_ff;                          // serial_port_enable
	logic       nine_sel_ff;                         // nine_bit_select
	logic       single_en_ff;                        // single_receive_enable
	logic       cont_en_ff;                          // continuous_receive_enable
	logic       overrun_ff;                          // overrun_error
	logic       clk_src_ff;                          // master_clock_source
	logic       clocked_ff;                          // Clocked mode select
	logic [7:0] baud_ff;                             // baud_divisor
	logic [7:0] rdata_ff;                            // Read data holding
	logic       nxt_single_en;                       // Next single enable
	logic       nxt_overrun;                         // Next overrun state
	logic [7:0] nxt_rdata;                           // Next read data

	// ------------------------------------------------------------
	// Receive engine state
	// ------------------------------------------------------------
	usr_state_t state_ff;                            // Engine state
	usr_state_t nxt_state;                           // Next engine state
	logic [7:0] div_ff;                              // Half-period counter
	logic [7:0] nxt_div;                             // Next counter value
	logic       ck_ff;                               // Shift clock level
	logic       nxt_ck;                              // Next shift clock level
	logic [3:0] bit_cnt_ff;                          // Bits taken this word
	logic [3:0] nxt_bit_cnt;                         // Next bit count
	logic [8:0] shift_ff;                            // receive_shift_register
	logic       dt_meta_ff;                          // Data pin first stage
	logic       dt_sync_ff;                          // Data pin second stage

	// ------------------------------------------------------------
	// Buffer link
	// ------------------------------------------------------------
	usr_word_t  fin_word;                            // Finished word
	usr_word_t  head_word;                           // Oldest buffered word
	logic       buf_full;                            // Buffer full
	logic       buf_empty;                           // Buffer empty
	logic [1:0] buf_count;                           // Buffer level

	// ------------------------------------------------------------
	// Engine decode
	// ------------------------------------------------------------
	logic       rx_enabled;                          // Reception allowed
	logic       running;                             // Clock may run
	logic       tick;                                // Half-period elapsed
	logic       fall;                                // Shift clock falls now
	logic [3:0] word_bits;                           // Bits in this word
	logic       word_done;                           // Last bit taken now
	logic [8:0] shift_in;                            // Shift value with new bit
	logic       push;                                // Move word to buffer
	logic       overrun_set;                         // Word lost to full buffer
	logic       single_end;                          // Single word finished
	logic       rx_flag;                             // receive_flag

	// Either enable starts reception; continuous wins when both set
	assign rx_enabled = port_en_ff && clocked_ff && clk_src_ff
		&& (single_en_ff || cont_en_ff);
	assign running    = (state_ff == ST_SHIFT) && rx_enabled;
	assign tick       = running && (div_ff == baud_ff);
	assign fall       = tick && ck_ff;
	assign word_bits  = nine_sel_ff ? BITS_LONG : BITS_SHORT;
	assign word_done  = fall && (bit_cnt_ff == word_bits - 4'h1);
	assign shift_in   = {dt_sync_ff, shift_ff[8:1]};

	// Eight-bit words sit one place higher in the shift register
	assign fin_word    = nine_sel_ff ? usr_word_t'(shift_in)
		: usr_word_t'({1'b0, shift_in[8:1]});
	assign push        = word_done && !buf_full && !overrun_ff;
	assign overrun_set = word_done && buf_full && !overrun_ff;
	assign single_end  = word_done && single_en_ff && !cont_en_ff;

	// Flag is simply the buffer holding a word; no software write path
	assign rx_flag = !buf_empty;

	// ------------------------------------------------------------
	// Next-state selection
	// ------------------------------------------------------------

	// Engine leaves idle as soon as reception is allowed
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (rx_enabled) begin
					nxt_state = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (!rx_enabled) begin
					nxt_state = ST_IDLE;
				end
			end
		endcase
	end

	assign nxt_div     = (running && !tick) ? div_ff + 8'h01 : 8'h00;
	assign nxt_ck      = running ? (ck_ff ^ tick) : 1'b0;
	assign nxt_bit_cnt = (!running || word_done) ? 4'h0
		: (fall ? bit_cnt_ff + 4'h1 : bit_cnt_ff);

	// Software setting the bit wins over the hardware stop
	assign nxt_single_en = wr_rx_ctl ? WDATA[BIT_SINGLE_RX_EN]
		: (single_end ? 1'b0 : single_en_ff);

	// A new overrun wins over the clear in the same cycle
	assign nxt_overrun = overrun_set ? 1'b1
		: ((wr_rx_ctl && !WDATA[BIT_CONT_RX_EN]) ? 1'b0 : overrun_ff);

	// ------------------------------------------------------------
	// Read multiplexer
	// ------------------------------------------------------------
	logic [7:0] rd_rx_ctl_val;                       // Status/control view
	logic [7:0] rd_flags_val;                        // Flag register view
	logic [7:0] rd_mode_val;                         // Port mode view
	logic [7:0] rd_buf_val;                          // Buffer head view
	logic [7:0] rd_mux;                              // Selected read value

	// Ninth bit shows the oldest buffered word
	assign rd_rx_ctl_val = {port_en_ff, nine_sel_ff, single_en_ff, cont_en_ff,
		2'b00, overrun_ff, head_word.ninth & rx_flag};
	assign rd_flags_val  = 8'(rx_flag) << BIT_RX_FLAG;
	assign rd_mode_val   = (8'(clk_src_ff) << BIT_MASTER_CLK_SRC)
		| (8'(clocked_ff) << BIT_CLOCKED_MODE);
	assign rd_buf_val    = rx_flag ? head_word.data : 8'h00;

	assign rd_mux =
		hit(ADDR, OFS_IRQ_CONTROL)        ? irq_ctl_ff    :
		hit(ADDR, OFS_PERIPH_IRQ_FLAGS)   ? rd_flags_val  :
		hit(ADDR, OFS_PERIPH_IRQ_ENABLES) ? periph_en_ff  :
		hit(ADDR, OFS_RX_STATUS_CONTROL)  ? rd_rx_ctl_val :
		hit(ADDR, OFS_RX_DATA_BUFFER)     ? rd_buf_val    :
		hit(ADDR, OFS_PORT_MODE)          ? rd_mode_val   :
		hit(ADDR, OFS_BAUD_DIVISOR)       ? baud_ff       : 8'h00;

	// Read data stands only in the cycle after the strobe
	assign nxt_rdata = RD ? rd_mux : 8'h00;

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------

	// Interrupt control and enables
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			irq_ctl_ff   <= RST_IRQ_CONTROL;
			periph_en_ff <= RST_PERIPH_EN;
		end else begin
			if (wr_irq_ctl) begin
				irq_ctl_ff <= WDATA;
			end
			if (wr_periph_en) begin
				periph_en_ff <= WDATA;
			end
		end
	end

	// Receive status/control fields
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			port_en_ff   <= 1'b0;
			nine_sel_ff  <= 1'b0;
			single_en_ff <= 1'b0;
			cont_en_ff   <= 1'b0;
			overrun_ff   <= 1'b0;
		end else begin
			if (wr_rx_ctl) begin
				port_en_ff  <= WDATA[BIT_SERIAL_PORT_EN];
				nine_sel_ff <= WDATA[BIT_NINE_BIT_SEL];
				cont_en_ff  <= WDATA[BIT_CONT_RX_EN];
			end
			single_en_ff <= nxt_single_en;
			overrun_ff   <= nxt_overrun;
		end
	end

	// Port mode, divisor and read data
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			clk_src_ff <= 1'b0;
			clocked_ff <= 1'b0;
			baud_ff    <= RST_BAUD_DIVISOR;
			rdata_ff   <= 8'h00;
		end else begin
			if (wr_port_mode) begin
				clk_src_ff <= WDATA[BIT_MASTER_CLK_SRC];
				clocked_ff <= WDATA[BIT_CLOCKED_MODE];
			end
			if (wr_baud) begin
				baud_ff <= WDATA;
			end
			rdata_ff <= nxt_rdata;
		end
	end

	// ------------------------------------------------------------
	// Receive engine
	// ------------------------------------------------------------

	// Data pin passes two stages before use
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			dt_meta_ff <= 1'b0;
			dt_sync_ff <= 1'b0;
		end else begin
			dt_meta_ff <= DT_I;
			dt_sync_ff <= dt_meta_ff;
		end
	end

	// Clock generation, bit counting and shifting
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_ff   <= ST_IDLE;
			div_ff     <= 8'h00;
			ck_ff      <= 1'b0;
			bit_cnt_ff <= 4'h0;
			shift_ff   <= 9'h000;
		end else begin
			state_ff   <= nxt_state;
			div_ff     <= nxt_div;
			ck_ff      <= nxt_ck;
			bit_cnt_ff <= nxt_bit_cnt;
			if (fall) begin
				shift_ff <= shift_in;
			end
		end
	end

	// ------------------------------------------------------------
	// Receive buffer
	// ------------------------------------------------------------
	usr_rx_fifo u_rx_fifo (
		.clk       (CLK),
		.rst       (SYS_RST),
		.push      (push),
		.push_word (fin_word),
		.pop       (rd_rx_buf),
		.head      (head_word),
		.full      (buf_full),
		.empty     (buf_empty),
		.count     (buf_count)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign RDATA = rdata_ff;
	assign CK_O  = ck_ff;
	assign CK_OE = port_en_ff && clocked_ff && clk_src_ff;

	// Flag gated by its own enable, then by both upper enables
	assign IRQ = rx_flag && periph_en_ff[BIT_RX_IRQ_EN]
		&& irq_ctl_ff[BIT_GLOBAL_IRQ_EN]
		&& irq_ctl_ff[BIT_PERIPH_IRQ_EN];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	a_start_on_enable: assert property (
		(state_ff == ST_IDLE) && rx_enabled |=> (state_ff == ST_SHIFT))
		else $error("Reception did not start");

	a_shift_on_fall: assert property (
		$changed(shift_ff) |-> $fell(ck_ff))
		else $error("Shift without falling clock");

	a_single_stops: assert property (
		single_end && !wr_rx_ctl |=> !single_en_ff ##1 (state_ff == ST_IDLE) && !CK_O)
		else $error("Single reception did not stop");

	a_cont_continues: assert property (
		word_done && cont_en_ff && !wr_rx_ctl |=> running && (bit_cnt_ff == 4'h0))
		else $error("Continuous reception stopped");

	a_word_pushed: assert property (
		push && !rd_rx_buf |=> (buf_count == $past(buf_count) + 2'h1) && rx_flag)
		else $error("Finished word not buffered");

	a_overrun_sets: assert property (
		word_done && buf_full && !rd_rx_buf && !wr_rx_ctl
		|=> overrun_ff && (buf_count == FIFO_DEPTH))
		else $error("Overrun not flagged");

	a_overrun_blocks: assert property (
		overrun_ff |=> (buf_count <= $past(buf_count)))
		else $error("Transfer during overrun");

	a_overrun_clears: assert property (
		wr_rx_ctl && !WDATA[BIT_CONT_RX_EN] && !overrun_set |=> !overrun_ff)
		else $error("Overrun not cleared");

	a_irq_gated: assert property (
		IRQ |-> irq_ctl_ff[BIT_GLOBAL_IRQ_EN] && irq_ctl_ff[BIT_PERIPH_IRQ_EN]
		&& periph_en_ff[BIT_RX_IRQ_EN] && !buf_empty)
		else $error("Interrupt without enables");

	a_clock_idle: assert property (
		!rx_enabled |=> !CK_O)
		else $error("Shift clock runs while idle");

	c_single_word: cover property (single_end);
	c_buffer_full: cover property (buf_full && word_done);
	c_overrun_clear: cover property (overrun_ff ##1 !overrun_ff);

endmodule
